// ### design/bus_result_hold.sv
`timescale 1ns/10ps
module bus_result_hold
    import pwr_sup_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // conversion input
    input  wire logic         conv_done,
    input  wire logic [W-1:0] conv_data,
    // held result and limits
    input  wire logic [15:0]  upper_lim,
    input  wire logic [15:0]  lower_lim,
    output logic      [W-1:0] result,
    output logic              at_upper,
    output logic              below_lower
);
    logic [W-1:0] next_result;

    always_comb begin
        next_result = result;
        if (conv_done) begin
            next_result = conv_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end

    // same encoding, signed compare; uses the value being
    // latched, so a strobe that ends a pass counts in its verdict
    assign at_upper    = $signed(next_result) >= $signed(upper_lim);
    assign below_lower = $signed(next_result) <  $signed(lower_lim);
endmodule

// ### design/pwr_sup_pkg.sv
package pwr_sup_pkg;
    // register pointers
    localparam logic [7:0]  CFG_PTR        = 8'h00;
    localparam logic [7:0]  PG_UPPER_PTR   = 8'h10;
    localparam logic [7:0]  PG_LOWER_PTR   = 8'h11;
    // power-on values
    localparam logic [15:0] CFG_RESET      = 16'h7127;
    localparam logic [15:0] PG_UPPER_RESET = 16'h2710;
    localparam logic [15:0] PG_LOWER_RESET = 16'h2328;
    // configuration fields
    localparam int          CFG_RST_BIT    = 15;
    localparam logic [2:0]  MODE_CONT_SB   = 3'h7;
    localparam int          MODE_LSB       = 0;
    // sequencing check: 1.2 V in bus-result encoding (8 mV/LSB, data at 3)
    localparam logic [15:0] SEQ_LEVEL      = 16'h04B0;
    localparam logic [2:0]  SEQ_CYCLES     = 3'h4;
    // nominal window with default timing, for reference
    localparam int          SEQ_WINDOW_US  = 28600;
    localparam int          CLK_MHZ        = 100;
    localparam int          SEQ_WINDOW_CYC = SEQ_WINDOW_US * CLK_MHZ;
    localparam int          NUM_CH         = 3;
endpackage

// ### design/pwr_supervisor.sv
// Operation
// - start in upper-threshold detection, default upper limit 10 V
// - power good goes high only when all three results reach upper limit
// - power good comes up low until first all-above-upper condition
// - after power good, watch for any channel below lower limit, 9 V
// - any channel below lower limit drops power good, back to upper wait
// - evaluate only after all three bus conversions of a pass finish
// - each bus result held until the next conversion on that channel
// - default continuous mode compares channel 1 with 1.2 V each pass
// - then channel 2 below 1.2 V at four pass ends after arming asserts alert
// - window is about 28.6 ms with default conversion settings
// - sequencing check runs only after power-up or software reset
// - configuration write before check finishes disables it
// - software reset restores defaults except power good level and bus results
// - software reset holds power good until fresh detection completes
// - software reset restores both power-good limits
// - upper limit pointer 10h, reset 2710h, compared to bus results
// - lower limit pointer 11h, reset 2328h, catches rail drop
// - configuration pointer 0, reset 7127h, reset bit and fields
`timescale 1ns/10ps
module pwr_supervisor
    import pwr_sup_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // register writes from the serial port
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_ptr,
    input  wire logic [15:0] reg_wdata,
    // bus conversion results, one strobe per channel
    input  wire logic [2:0]  bus_done,
    input  wire logic [47:0] bus_data,
    // register read-back
    output logic      [15:0] cfg,
    output logic      [15:0] pg_upper,
    output logic      [15:0] pg_lower,
    output logic      [47:0] bus_result,
    // open-drain outputs: power good high when good, sequencing alert low active
    output logic             power_good_output_o,
    output logic             power_good_output_oe,
    output logic             seq_alert_b_o,
    output logic             seq_alert_b_oe
);
    typedef enum logic [1:0] {
        PG_WAIT_UPPER = 2'b01,
        PG_WATCH_LOW  = 2'b10
    } pg_state_t;

    typedef enum logic [3:0] {
        SQ_WAIT_CH1 = 4'b0001,
        SQ_WAIT_CH2 = 4'b0010,
        SQ_ALERT    = 4'b0100,
        SQ_OFF      = 4'b1000
    } sq_state_t;

    logic [2:0]  at_upper;
    logic [2:0]  below_lower;
    logic        all_upper;
    logic        any_lower;
    logic [2:0]  pass_seen;
    logic [2:0]  next_pass_seen;
    logic        pass_end;
    logic        soft_rst;
    logic        next_soft_rst;
    logic        cfg_wr;
    logic [15:0] next_cfg;
    logic [15:0] next_pg_upper;
    logic [15:0] next_pg_lower;
    pg_state_t   pg_state;
    pg_state_t   next_pg_state;
    logic        pg_level;
    logic        next_pg_level;
    sq_state_t   sq_state;
    sq_state_t   next_sq_state;
    logic [2:0]  sq_count;
    logic [2:0]  next_sq_count;
    logic        seq_low;
    logic        next_seq_low;
    logic        next_pg_oe;
    logic        next_seq_oe;

    // per-channel held results and comparisons
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        bus_result_hold #(
            .W (16)
        ) u_hold (
            .sys_clk     (sys_clk),
            .rst_b       (rst_b),
            .conv_done   (bus_done[c]),
            .conv_data   (bus_data[16*c +: 16]),
            .upper_lim   (pg_upper),
            .lower_lim   (pg_lower),
            .result      (bus_result[16*c +: 16]),
            .at_upper    (at_upper[c]),
            .below_lower (below_lower[c])
        );
    end

    // pass verdicts over all three channels; fresh values included,
    // otherwise a joint strobe would be judged on stale results
    assign all_upper = &at_upper;
    assign any_lower = |below_lower;

    // register writes; soft reset is a one-cycle pulse after the write
    // a write landing in the soft-reset cycle loses to the defaults
    assign cfg_wr = reg_wr && (reg_ptr == CFG_PTR);

    always_comb begin
        next_cfg      = cfg;
        next_pg_upper = pg_upper;
        next_pg_lower = pg_lower;
        next_soft_rst = 1'b0;
        if (soft_rst) begin
            next_cfg      = CFG_RESET;
            next_pg_upper = PG_UPPER_RESET;
            next_pg_lower = PG_LOWER_RESET;
        end else if (reg_wr) begin
            case (reg_ptr)
                CFG_PTR: begin
                    next_cfg      = reg_wdata;
                    next_cfg[CFG_RST_BIT] = 1'b0;
                    next_soft_rst = reg_wdata[CFG_RST_BIT];
                end
                PG_UPPER_PTR: next_pg_upper = reg_wdata;
                PG_LOWER_PTR: next_pg_lower = reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg      <= CFG_RESET;
            pg_upper <= PG_UPPER_RESET;
            pg_lower <= PG_LOWER_RESET;
            soft_rst <= 1'b0;
        end else begin
            cfg      <= next_cfg;
            pg_upper <= next_pg_upper;
            pg_lower <= next_pg_lower;
            soft_rst <= next_soft_rst;
        end
    end

    // pass tracking: a pass ends when every channel has refreshed
    // strobes may coincide; a joint strobe ends a pass at once
    always_comb begin
        next_pass_seen = pass_seen | bus_done;
        pass_end       = &next_pass_seen;
        if (pass_end || soft_rst) begin
            next_pass_seen = 3'h0;
        end
    end

    // power good machine
    always_comb begin
        next_pg_state = pg_state;
        next_pg_level = pg_level;
        if (soft_rst) begin
            next_pg_state = PG_WAIT_UPPER;
        end else if (pass_end) begin
            case (pg_state)
                PG_WAIT_UPPER: begin
                    if (all_upper) begin
                        next_pg_level = 1'b1;
                        next_pg_state = PG_WATCH_LOW;
                    end else begin
                        next_pg_level = 1'b0;
                    end
                end
                PG_WATCH_LOW: begin
                    if (any_lower) begin
                        next_pg_level = 1'b0;
                        next_pg_state = PG_WAIT_UPPER;
                    end
                end
                default: begin
                    next_pg_state = PG_WAIT_UPPER;
                    next_pg_level = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pg_state <= PG_WAIT_UPPER;
            pg_level <= 1'b0;
        end else begin
            pg_state <= next_pg_state;
            pg_level <= next_pg_level;
        end
    end

    // sequencing check; incoming conversion data compares with 1.2 V code
    // no long timer: the window is kept in passes, so it scales
    // the pass in which channel 1 arms counts as the first of four unless its strobe ends that pass
    always_comb begin
        next_sq_state = sq_state;
        next_sq_count = sq_count;
        next_seq_low  = seq_low;
        if (soft_rst) begin
            next_sq_state = SQ_WAIT_CH1;
            next_sq_count = 3'h0;
            next_seq_low  = 1'b0;
        end else if (cfg_wr && (sq_state == SQ_WAIT_CH1 ||
                                sq_state == SQ_WAIT_CH2)) begin
            next_sq_state = SQ_OFF;
        end else begin
            case (sq_state)
                SQ_WAIT_CH1: begin
                    if (bus_done[0] &&
                        $signed(bus_data[15:0]) >= $signed(SEQ_LEVEL)) begin
                        next_sq_state = SQ_WAIT_CH2;
                        next_sq_count = 3'h0;
                    end
                end
                SQ_WAIT_CH2: begin
                    if (bus_done[1] &&
                        $signed(bus_data[31:16]) >= $signed(SEQ_LEVEL)) begin
                        next_sq_state = SQ_OFF;
                    end else if (pass_end) begin
                        next_sq_count = sq_count + 3'h1;
                        if (sq_count + 3'h1 >= SEQ_CYCLES) begin
                            next_sq_state = SQ_ALERT;
                            next_seq_low  = 1'b1;
                        end
                    end
                end
                SQ_ALERT: next_seq_low = 1'b1;
                SQ_OFF:   ;
                default: begin
                    next_sq_state = SQ_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sq_state  <= SQ_WAIT_CH1;
            sq_count  <= 3'h0;
            seq_low   <= 1'b0;
        end else begin
            sq_state  <= next_sq_state;
            sq_count  <= next_sq_count;
            seq_low   <= next_seq_low;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pass_seen <= 3'h0;
        end else begin
            pass_seen <= next_pass_seen;
        end
    end

    // pin enables; o stays 0 so the pad never drives high and
    // the board pull-up alone makes the released level
    always_comb begin
        next_pg_oe  = !next_pg_level;
        next_seq_oe = next_seq_low;
    end

    // open-drain pins: output bit always 0, enable pulls low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            power_good_output_o  <= 1'b0;
            power_good_output_oe <= 1'b1;
            seq_alert_b_o        <= 1'b0;
            seq_alert_b_oe       <= 1'b0;
        end else begin
            power_good_output_o  <= 1'b0;
            power_good_output_oe <= next_pg_oe;
            seq_alert_b_o        <= 1'b0;
            seq_alert_b_oe       <= next_seq_oe;
        end
    end
endmodule

// ### verif/host_model.sv
`timescale 1ns/10ps
module host_model (
    // clock
    input  wire logic        sys_clk,
    // register writes and conversion results
    output logic             reg_wr,
    output logic [7:0]       reg_ptr,
    output logic [15:0]      reg_wdata,
    output logic [2:0]       bus_done,
    output logic [47:0]      bus_data
);
    initial begin
        {reg_wr, reg_ptr, reg_wdata, bus_done, bus_data} = '0;
    end
    // settings rewritten by the caller after power-up
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_ptr, reg_wdata} = {1'b1, p, d};
        @(negedge sys_clk);
        {reg_wr, reg_ptr, reg_wdata} = {1'b0, ~p, ~d}; // stale bus
    endtask
    // one bus pass per call; m 0 joint, 1 back-to-back, 2 slow
    task automatic pass(input logic [47:0] v, input int m);
        logic [47:0] d;
        for (int c = 0; c < 3; c++) begin
            if (m != 0 || c == 0) begin
                d = ~v;
                d[c*16+:16] = v[c*16+:16];
                @(negedge sys_clk);
                bus_done = (m == 0) ? 3'h7 : 3'h1 << c;
                bus_data = (m == 0) ? v : d;
                if (m == 2) begin
                    @(negedge sys_clk);
                    bus_done = 3'h0;
                end
            end
        end
        @(negedge sys_clk);
        {bus_done, bus_data} = {3'h0, ~v};
    endtask
endmodule

// ### verif/pwr_supervisor_chk.sv
`timescale 1ns/10ps
module pwr_supervisor_chk
    import pwr_sup_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // host side
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_ptr,
    input wire logic [15:0] reg_wdata,
    input wire logic [2:0]  bus_done,
    input wire logic [47:0] bus_data,
    // read-back and pins
    input wire logic [15:0] cfg,
    input wire logic [15:0] pg_upper,
    input wire logic [15:0] pg_lower,
    input wire logic [47:0] bus_result,
    input wire logic        power_good_output_o,
    input wire logic        power_good_output_oe,
    input wire logic        seq_alert_b_o,
    input wire logic        seq_alert_b_oe
);
    logic [2:0] seen, next_seen, up, lo;
    logic       fresh, next_fresh, srst_d, srst_w, pass_end;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // signed compares of held results against the live limits
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            up[c] = $signed(bus_result[c*16+:16]) >= $signed(pg_upper);
            lo[c] = $signed(bus_result[c*16+:16]) < $signed(pg_lower);
        end
    end
    assign srst_w   = reg_wr && reg_ptr == CFG_PTR && reg_wdata[CFG_RST_BIT];
    // a pass ending in the soft-reset cycle is dropped by the design
    assign pass_end = &(seen | bus_done) && !srst_d;
    // fresh marks the detection pass after a soft reset, which skips
    // the lower-limit state
    always_comb begin
        next_seen  = (pass_end || srst_d) ? 3'h0 : (seen | bus_done);
        next_fresh = srst_w | (fresh & ~pass_end);
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            seen   <= 3'h0;
            fresh  <= 1'b0;
            srst_d <= 1'b0;
        end else begin
            seen   <= next_seen;
            fresh  <= next_fresh;
            srst_d <= srst_w;
        end
    end
    pg_reset_low_a:
        assert property ($rose(rst_b) |-> power_good_output_oe
            && !seq_alert_b_oe) else $error("pins wrong after reset");
    pg_hold_a:
        assert property (!pass_end |=> $stable(power_good_output_oe))
            else $error("power good moved mid-pass");
    pg_rise_a:
        assert property (pass_end && power_good_output_oe
            |=> power_good_output_oe == !(&up)) else $error("upper wait");
    pg_drop_a:
        assert property (pass_end && !power_good_output_oe && !fresh
            |=> power_good_output_oe == |lo) else $error("lower watch");
    srst_default_a:
        assert property (srst_w |=> ##1 cfg == CFG_RESET && pg_upper ==
            PG_UPPER_RESET && pg_lower == PG_LOWER_RESET)
            else $error("soft reset defaults");
    lim_write_a:
        assert property (reg_wr && reg_ptr == PG_LOWER_PTR && !srst_d
            |=> pg_lower == $past(reg_wdata)) else $error("lower write");
    result_hold_a:
        assert property (!bus_done[1] && !srst_d
            |=> $stable(bus_result[31:16])) else $error("result moved");
    seq_latch_a:
        assert property (seq_alert_b_oe && !srst_d |=> seq_alert_b_oe)
            else $error("sequencing alert released");
endmodule
bind pwr_supervisor pwr_supervisor_chk u_chk (
    .sys_clk, .rst_b, .reg_wr, .reg_ptr, .reg_wdata, .bus_done, .bus_data,
    .cfg, .pg_upper, .pg_lower, .bus_result, .power_good_output_o,
    .power_good_output_oe, .seq_alert_b_o, .seq_alert_b_oe
);

// ### verif/pwr_supervisor_tb_top.sv
`timescale 1ns/10ps
module pwr_supervisor_tb_top import pwr_sup_pkg::*;;
    logic        sys_clk, rst_b, reg_wr, good, fresh;
    logic [7:0]  reg_ptr;
    logic [15:0] reg_wdata, cfg, pg_upper, pg_lower, up, lo;
    logic [2:0]  bus_done;
    logic [47:0] bus_data, bus_result, v;
    logic        power_good_output_o, power_good_output_oe;
    logic        seq_alert_b_o, seq_alert_b_oe;
    int          errors, cmp_count, seed;
    // open-drain pins with pull-ups
    wire pg_pin = power_good_output_oe ? power_good_output_o : 1'b1;
    wire sq_pin = seq_alert_b_oe ? seq_alert_b_o : 1'b1;
    pwr_supervisor dut (.sys_clk, .rst_b, .reg_wr, .reg_ptr, .reg_wdata,
        .bus_done, .bus_data, .cfg, .pg_upper, .pg_lower, .bus_result,
        .power_good_output_o, .power_good_output_oe, .seq_alert_b_o,
        .seq_alert_b_oe);
    host_model host (.sys_clk, .reg_wr, .reg_ptr, .reg_wdata, .bus_done,
        .bus_data);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [47:0] e, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [15:0] rnd(input logic [15:0] b, m);
        return b + (16'($random(seed)) & m);
    endfunction
    // expected level after a pass: upper wait when low, lower watch else
    function automatic logic pg_next(input logic g, input logic [47:0] x);
        logic a, d;
        {a, d} = 2'b10;
        for (int c = 0; c < 3; c++) begin
            a &= $signed(x[c*16+:16]) >= $signed(up);
            d |= $signed(x[c*16+:16]) < $signed(lo);
        end
        return g ? !d : a;
    endfunction
    task automatic run(input logic [47:0] x, input int m);
        host.pass(x, m);
        good = pg_next(good && !fresh, x);
        fresh = 1'b0;
        @(negedge sys_clk);
        chk("power good", good, pg_pin);
        chk("results", x, bus_result);
    endtask
    task automatic srst();
        host.wr(CFG_PTR, 16'h8000);
        @(negedge sys_clk);
        {up, lo, fresh} = {PG_UPPER_RESET, PG_LOWER_RESET, 1'b1};
        chk("cfg", CFG_RESET, cfg);
        chk("limits", {up, lo}, {pg_upper, pg_lower});
        chk("power good", good, pg_pin);
        chk("seq alert", 1'b1, sq_pin);
    endtask
    // random passes; each channel above, in band or below
    task automatic mix(input int n);
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < 3; c++)
                case ($unsigned($random(seed)) % 4)
                    0, 1: v[c*16+:16] = rnd(up, 16'h0FF8);
                    2: v[c*16+:16] = rnd(lo, 16'h01FF);
                    default: v[c*16+:16] = rnd(16'h0000, 16'h1FF8);
                endcase
            run(v, i % 3);
        end
    endtask
    initial begin
        #200_000;
        errors++;
        conclude();
    end
    initial begin
        {errors, cmp_count, seed, good, fresh, rst_b} = {32'd0, 32'd0, 32'd87, 3'b0};
        {up, lo} = {PG_UPPER_RESET, PG_LOWER_RESET};
        repeat (16) @(negedge sys_clk);
        rst_b = 1'b1;
        chk("cfg", CFG_RESET, cfg);
        chk("limits", {up, lo}, {pg_upper, pg_lower});
        chk("power good", 1'b0, pg_pin);
        chk("results", 48'h0, bus_result);
        // ch1 at the level arms, ch2 just under it
        run({16'h0100, 16'h04AF, SEQ_LEVEL}, 1);
        for (int i = 1; i <= 5; i++) begin
            run({16'h0100, rnd(0, 16'h03F8), rnd(SEQ_LEVEL, 16'h00FF)}, i % 3);
            if (i == 2) chk("seq alert", 1'b1, sq_pin);
            if (i >= 4) chk("seq alert", 1'b0, sq_pin);
        end
        srst();
        // a configuration write while armed cancels the check
        run({16'h0100, 16'h0100, SEQ_LEVEL}, 0);
        host.wr(CFG_PTR, 16'h7125);
        chk("cfg", 16'h7125, cfg);
        for (int i = 0; i < 5; i++) run({16'h0100, 16'h0100, SEQ_LEVEL}, 2);
        chk("seq alert", 1'b1, sq_pin);
        // boundary passes, then random hysteresis traffic
        run({up, up, lo}, 1);
        run({up, up, up}, 0);
        run({lo, lo, lo}, 2);
        run({lo, lo - 16'h1, lo}, 1);
        run({up - 16'h1, up, up}, 0);
        mix(16);
        // new limits, an unused pointer, then soft reset restores
        up = rnd(16'h1000, 16'h0FFF);
        lo = rnd(16'h0800, 16'h07FF);
        host.wr(PG_UPPER_PTR, up);
        host.wr(PG_LOWER_PTR, lo);
        host.wr(8'h12, 16'h0000);
        chk("limits", {up, lo}, {pg_upper, pg_lower});
        mix(8);
        run({up, up, up}, 1);
        srst();
        run({up, up - 16'h1, up}, 2);
        mix(8);
        conclude();
    end
endmodule
